// file: common/chf_pkg.sv
/*
  shared types and constants for the card host-port flow-control block.
  assumes one system clock domain and one link (strobe) clock domain.
*/
package chf_pkg;
  typedef enum logic [1:0] {
    CHF_MODE_MEMORY = 2'h0,
    CHF_MODE_IO = 2'h1,
    CHF_MODE_DISK = 2'h2
  } chf_mode_t;

  // data-out burst states, gray along idle -> run -> pause
  typedef enum logic [1:0] {
    CHF_OUT_IDLE = 2'h0,
    CHF_OUT_RUN = 2'h1,
    CHF_OUT_PAUSE = 2'h3
  } chf_out_st_t;

  localparam int unsigned CHF_DATA_W = 16;
  localparam int unsigned CHF_ADDR_W = 4;

  typedef struct packed {
    logic [CHF_ADDR_W-1:0] addr;
    logic [CHF_DATA_W-1:0] data;
    logic attr;
  } chf_wr_t;

  localparam logic [1:0] CHF_SYNC_RST = 2'h0;
  localparam logic [CHF_DATA_W-1:0] CHF_WORD_RST = 16'h0000;
endpackage

// file: hw/chf_skid.sv
/*
  two-entry buffer with valid/ready on both sides.
  assumes a single clock; ready falls only when both entries are full.
*/
`timescale 1ns/1ps
module chf_skid #(
  parameter int unsigned W = 16
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // fill side
  input wire logic i_valid,
  input wire logic [W-1:0] i_data,
  output logic o_ready,
  // drain side
  output logic o_valid,
  output logic [W-1:0] o_data,
  input wire logic i_ready
);
  initial begin
    if (W < 1) $error("chf_skid: W must be at least 1");
  end

  logic [W-1:0] mem_q [2];
  logic [W-1:0] mem_d [2];
  logic [1:0] cnt_q, cnt_d;
  logic rd_q, rd_d;
  logic wr_q, wr_d;
  logic rdy_q, rdy_d;
  logic push, pop;

  // ready is registered so the top-level ready output comes from a flop
  assign o_ready = rdy_q;
  assign o_valid = (cnt_q != 2'h0);
  assign o_data = mem_q[rd_q];

  always_comb begin
    push = i_valid && o_ready;
    pop = o_valid && i_ready;
    mem_d = mem_q;
    wr_d = wr_q;
    rd_d = rd_q;
    if (push) begin
      mem_d[wr_q] = i_data;
      wr_d = ~wr_q;
    end
    if (pop) begin
      rd_d = ~rd_q;
    end
    cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
    rdy_d = (cnt_d != 2'h2);
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
      cnt_q <= 2'h0;
      rdy_q <= 1'b1;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
    end else if (i_ce) begin
      mem_q <= mem_d;
      cnt_q <= cnt_d;
      rdy_q <= rdy_d;
      rd_q <= rd_d;
      wr_q <= wr_d;
    end
  end
endmodule

// file: hw/chf_flow.sv
/*
  flow control of the card host port: wait/ready hold-off, register write
  strobe capture, and the data-in ready / data-out strobe of fast dma.
  assumes host pins arrive asynchronously; the data-out strobe is made in the
  link clock domain (i_clk_link, free running) and words cross to it by a
  toggle handshake from the system side.
*/
`timescale 1ns/1ps
module chf_flow #(
  parameter int unsigned DATA_W = chf_pkg::CHF_DATA_W
) (
  // system clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // link clock for the data-out strobe
  input wire logic i_clk_link,
  // mode and core status
  input wire chf_pkg::chf_mode_t i_mode,
  input wire logic i_udma_write,
  input wire logic i_udma_read,
  input wire logic i_core_ready,
  input wire logic i_core_can_take,
  // host pins
  input wire logic i_cycle_active,
  input wire logic i_we_n,
  input wire logic [chf_pkg::CHF_ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_host_data,
  input wire logic i_reg_n,
  // outputs to host
  output logic o_wait_n,
  output logic o_dmardy_n,
  output logic o_dstrobe,
  output logic [DATA_W-1:0] o_dout,
  // core side
  output chf_pkg::chf_wr_t o_task_wr,
  output logic o_task_wr_vld,
  output chf_pkg::chf_wr_t o_cfg_wr,
  output logic o_cfg_wr_vld,
  input wire logic i_out_valid,
  input wire logic [DATA_W-1:0] i_out_data,
  output logic o_out_ready
);
  initial begin
    if (DATA_W != chf_pkg::CHF_DATA_W) $error("chf_flow: DATA_W must match package");
  end

  // pin synchronisers, two flops each
  logic [1:0] cyc_s_q, we_s_q;
  logic we_prev_q;
  logic [chf_pkg::CHF_ADDR_W-1:0] addr_s1_q, addr_s2_q;
  logic [DATA_W-1:0] data_s1_q, data_s2_q;
  logic reg_s1_q, reg_s2_q;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cyc_s_q <= chf_pkg::CHF_SYNC_RST;
      we_s_q <= 2'h3;
      we_prev_q <= 1'b1;
      addr_s1_q <= '0;
      addr_s2_q <= '0;
      data_s1_q <= chf_pkg::CHF_WORD_RST;
      data_s2_q <= chf_pkg::CHF_WORD_RST;
      reg_s1_q <= 1'b1;
      reg_s2_q <= 1'b1;
    end else if (i_ce) begin
      cyc_s_q <= {cyc_s_q[0], i_cycle_active};
      we_s_q <= {we_s_q[0], i_we_n};
      we_prev_q <= we_s_q[1];
      addr_s1_q <= i_addr;
      addr_s2_q <= addr_s1_q;
      data_s1_q <= i_host_data;
      data_s2_q <= data_s1_q;
      reg_s1_q <= i_reg_n;
      reg_s2_q <= reg_s1_q;
    end
  end

  // wait / ready and data-ready
  logic wait_n_q, wait_n_d;
  logic dmardy_n_q, dmardy_n_d;
  logic we_rise;
  logic udma;

  always_comb begin
    udma = i_udma_write || i_udma_read;
    we_rise = we_s_q[1] && !we_prev_q;
    wait_n_d = 1'b1;
    if (cyc_s_q[1] && !i_core_ready) begin
      if (i_mode != chf_pkg::CHF_MODE_DISK) begin
        wait_n_d = 1'b0;
      end else if (!udma) begin
        wait_n_d = 1'b0;
      end
    end
    // held low until the core can finish, the synced cycle ends or disk-mode udma starts
    if (i_core_ready) begin
      wait_n_d = 1'b1;
    end
    dmardy_n_d = 1'b1;
    if (i_mode == chf_pkg::CHF_MODE_DISK && i_udma_write) begin
      dmardy_n_d = !i_core_can_take;
    end
  end

  // write strobe capture on the rising (completing) edge
  chf_pkg::chf_wr_t task_q, task_d, cfg_q, cfg_d;
  logic task_vld_q, task_vld_d, cfg_vld_q, cfg_vld_d;

  always_comb begin
    task_d = task_q;
    cfg_d = cfg_q;
    task_vld_d = 1'b0;
    cfg_vld_d = 1'b0;
    if (we_rise && i_mode != chf_pkg::CHF_MODE_DISK) begin
      if (!reg_s2_q) begin
        cfg_d = '{addr: addr_s2_q, data: data_s2_q, attr: 1'b1};
        cfg_vld_d = 1'b1;
      end else if (i_mode == chf_pkg::CHF_MODE_MEMORY) begin
        task_d = '{addr: addr_s2_q, data: data_s2_q, attr: 1'b0};
        task_vld_d = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wait_n_q <= 1'b1;
      dmardy_n_q <= 1'b1;
      task_q <= '0;
      cfg_q <= '0;
      task_vld_q <= 1'b0;
      cfg_vld_q <= 1'b0;
    end else if (i_ce) begin
      wait_n_q <= wait_n_d;
      dmardy_n_q <= dmardy_n_d;
      task_q <= task_d;
      cfg_q <= cfg_d;
      task_vld_q <= task_vld_d;
      cfg_vld_q <= cfg_vld_d;
    end
  end

  assign o_wait_n = wait_n_q;
  assign o_dmardy_n = dmardy_n_q;
  assign o_task_wr = task_q;
  assign o_task_wr_vld = task_vld_q;
  assign o_cfg_wr = cfg_q;
  assign o_cfg_wr_vld = cfg_vld_q;

  // data-out path: buffer, then toggle handshake to the link domain
  logic buf_valid, buf_ready;
  logic [DATA_W-1:0] buf_data;

  chf_skid #(.W(DATA_W)) u_skid (
    .i_clk(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_valid(i_out_valid),
    .i_data(i_out_data),
    .o_ready(o_out_ready),
    .o_valid(buf_valid),
    .o_data(buf_data),
    .i_ready(buf_ready)
  );

  logic req_q, req_d, busy_q, busy_d;
  logic [DATA_W-1:0] hold_q, hold_d;
  logic [1:0] ack_s_q;
  logic ack_prev_q;
  logic burst_on;
  logic lk_ack_q, lk_ack_d;

  always_comb begin
    burst_on = (i_mode == chf_pkg::CHF_MODE_DISK) && i_udma_read;
    buf_ready = !busy_q && burst_on;
    req_d = req_q;
    busy_d = busy_q;
    hold_d = hold_q;
    if (buf_ready && buf_valid) begin
      hold_d = buf_data;
      req_d = ~req_q;
      busy_d = 1'b1;
    end else if (busy_q && (ack_s_q[1] != ack_prev_q)) begin
      busy_d = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      req_q <= 1'b0;
      busy_q <= 1'b0;
      hold_q <= chf_pkg::CHF_WORD_RST;
      ack_s_q <= chf_pkg::CHF_SYNC_RST;
      ack_prev_q <= 1'b0;
    end else if (i_ce) begin
      req_q <= req_d;
      busy_q <= busy_d;
      hold_q <= hold_d;
      ack_s_q <= {ack_s_q[0], lk_ack_q};
      ack_prev_q <= ack_s_q[1];
    end
  end

  // link domain: one strobe edge per word, level held when no word waits
  // a word is pending while the synced request differs from our ack, so a
  // toggle that lands while the burst is still starting up is not lost
  logic [1:0] lk_req_s_q;
  logic lk_strobe_q, lk_strobe_d;
  logic [DATA_W-1:0] lk_dout_q, lk_dout_d;
  logic [1:0] lk_on_s_q;
  chf_pkg::chf_out_st_t lk_st_q, lk_st_d;

  always_comb begin
    lk_st_d = lk_st_q;
    lk_strobe_d = lk_strobe_q;
    lk_dout_d = lk_dout_q;
    lk_ack_d = lk_ack_q;
    unique case (lk_st_q)
      chf_pkg::CHF_OUT_IDLE: begin
        if (lk_on_s_q[1]) begin
          lk_st_d = chf_pkg::CHF_OUT_RUN;
        end
      end
      chf_pkg::CHF_OUT_RUN, chf_pkg::CHF_OUT_PAUSE: begin
        if (lk_req_s_q[1] != lk_ack_q) begin
          lk_dout_d = hold_q;
          lk_strobe_d = ~lk_strobe_q;
          lk_ack_d = ~lk_ack_q;
          lk_st_d = chf_pkg::CHF_OUT_RUN;
        end else begin
          lk_st_d = chf_pkg::CHF_OUT_PAUSE;
        end
        if (!lk_on_s_q[1]) begin
          lk_st_d = chf_pkg::CHF_OUT_IDLE;
        end
      end
      default: lk_st_d = chf_pkg::CHF_OUT_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_link or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lk_req_s_q <= chf_pkg::CHF_SYNC_RST;
      lk_on_s_q <= chf_pkg::CHF_SYNC_RST;
      lk_ack_q <= 1'b0;
      lk_strobe_q <= 1'b0;
      lk_dout_q <= chf_pkg::CHF_WORD_RST;
      lk_st_q <= chf_pkg::CHF_OUT_IDLE;
    end else begin
      lk_req_s_q <= {lk_req_s_q[0], req_q};
      lk_on_s_q <= {lk_on_s_q[0], burst_on};
      lk_ack_q <= lk_ack_d;
      lk_strobe_q <= lk_strobe_d;
      lk_dout_q <= lk_dout_d;
      lk_st_q <= lk_st_d;
    end
  end

  assign o_dstrobe = lk_strobe_q;
  assign o_dout = lk_dout_q;
endmodule

// file: dv/chf_flow_checker.sv
/*
  assertions on the flow-control block ports.
  bound to chf_flow from the bench top file; sees its ports only.
*/
`timescale 1ns/1ps
module chf_flow_checker (
  // clocks and reset
  input wire logic i_clk_sys,
  input wire logic i_clk_link,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // inputs
  input wire chf_pkg::chf_mode_t i_mode,
  input wire logic i_udma_write,
  input wire logic i_udma_read,
  input wire logic i_core_ready,
  input wire logic i_core_can_take,
  input wire logic i_cycle_active,
  input wire logic i_we_n,
  input wire logic i_reg_n,
  // outputs
  input wire logic o_wait_n,
  input wire logic o_dmardy_n,
  input wire logic o_dstrobe,
  input wire logic [15:0] o_dout,
  input wire logic o_task_wr_vld,
  input wire logic o_cfg_wr_vld
);
  a_wait_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_ce && i_cycle_active && !i_core_ready && i_mode != chf_pkg::CHF_MODE_DISK)[*4]
    |-> !o_wait_n) else $error("wait not driven");
  a_iordy_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_ce && i_cycle_active && !i_core_ready && i_mode == chf_pkg::CHF_MODE_DISK
    && !i_udma_write && !i_udma_read)[*4] |-> !o_wait_n) else $error("ready not driven");
  a_wait_release: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    i_ce && !o_wait_n && i_core_ready |=> o_wait_n) else $error("wait not released");
  a_rdy_follow: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    i_ce && i_mode == chf_pkg::CHF_MODE_DISK && i_udma_write
    |=> o_dmardy_n == !$past(i_core_can_take)) else $error("data ready wrong");
  a_task_mode: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    o_task_wr_vld |-> $past(i_mode) == chf_pkg::CHF_MODE_MEMORY) else $error("task write");
  a_cfg_mode: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    o_cfg_wr_vld |-> $past(i_mode) != chf_pkg::CHF_MODE_DISK) else $error("cfg in disk");
  a_cfg_strobe: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    i_ce && $rose(i_we_n) && !i_reg_n && i_mode != chf_pkg::CHF_MODE_DISK
    |-> ##[3:5] o_cfg_wr_vld) else $error("cfg write lost");
  a_out_steady: assert property (@(posedge i_clk_link) disable iff (!i_rst_n)
    !$stable(o_dout) |-> !$stable(o_dstrobe)) else $error("word moved without strobe");
endmodule

// file: dv/chf_host_model.sv
/*
  host end of the fast dma data-out path: takes a word on each strobe edge.
  assumes strobe and word change together on the rising link edge.
*/
`timescale 1ns/1ps
module chf_host_model (
  // link side
  input wire logic i_clk_link,
  input wire logic i_rst_n,
  input wire logic i_dstrobe,
  input wire logic [15:0] i_dout,
  // capture result
  output logic [7:0] o_cnt,
  output logic [15:0] o_last
);
  logic strobe_q;
  // falling link edge, half a period away from where the device updates
  always @(negedge i_clk_link or negedge i_rst_n) begin
    if (!i_rst_n) begin
      strobe_q <= 1'b0;
      o_cnt <= 8'h00;
      o_last <= 16'h0000;
    end else if (i_dstrobe !== strobe_q) begin
      strobe_q <= i_dstrobe;
      o_cnt <= o_cnt + 8'h01;
      o_last <= i_dout;
    end
  end
endmodule

// file: dv/chf_flow_tb.sv
/*
  self-checking bench for chf_flow with a host model on the data-out path.
  assumes 100 MHz system clock and an 80 ns link clock.
*/
`timescale 1ns/1ps
module chf_flow_tb;
  localparam chf_pkg::chf_mode_t MEM = chf_pkg::CHF_MODE_MEMORY;
  localparam chf_pkg::chf_mode_t IOM = chf_pkg::CHF_MODE_IO;
  localparam chf_pkg::chf_mode_t DSK = chf_pkg::CHF_MODE_DISK;
  logic i_clk_sys = 1'b0, i_clk_link = 1'b0, i_rst_n = 1'b0, i_ce = 1'b1;
  chf_pkg::chf_mode_t i_mode = MEM;
  logic i_udma_write = 1'b0, i_udma_read = 1'b0, i_core_ready = 1'b1;
  logic i_core_can_take = 1'b0, i_cycle_active = 1'b0, i_we_n = 1'b1, i_reg_n = 1'b1;
  logic [3:0] i_addr = 4'h0;
  logic [15:0] i_host_data = 16'h0000, i_out_data = 16'h0000, o_dout, w_task, w_cfg;
  logic i_out_valid = 1'b0, o_wait_n, o_dmardy_n, o_dstrobe, o_out_ready;
  logic o_task_wr_vld, o_cfg_wr_vld;
  chf_pkg::chf_wr_t o_task_wr, o_cfg_wr;
  logic [7:0] host_cnt;
  logic [15:0] host_last;
  int num_errors = 0, n_tests = 0, n_task = 0, n_cfg = 0;

  always #5 i_clk_sys = ~i_clk_sys;
  always #40 i_clk_link = ~i_clk_link;

  chf_flow DUT (.*);
  chf_host_model u_host (.i_clk_link(i_clk_link), .i_rst_n(i_rst_n), .i_dstrobe(o_dstrobe),
    .i_dout(o_dout), .o_cnt(host_cnt), .o_last(host_last));

  always @(posedge i_clk_sys) begin
    if (o_task_wr_vld === 1'b1) begin
      n_task++;
      w_task = o_task_wr.data;
    end
    if (o_cfg_wr_vld === 1'b1) begin
      n_cfg++;
      w_cfg = o_cfg_wr.data;
    end
  end

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic end_sim;
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // host cycle held off by a busy core, then released
  task automatic t_wait(input chf_pkg::chf_mode_t m, input logic dma, input logic exp_n);
    i_mode <= m;
    i_udma_read <= dma;
    i_core_ready <= 1'b0;
    i_cycle_active <= 1'b1;
    repeat (6) @(posedge i_clk_sys);
    #1 chk("wait held", {15'h0, exp_n}, {15'h0, o_wait_n});
    @(posedge i_clk_sys);
    i_core_ready <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    #1 chk("wait freed", 16'h1, {15'h0, o_wait_n});
    @(posedge i_clk_sys);
    i_cycle_active <= 1'b0;
    i_udma_read <= 1'b0;
    repeat (3) @(posedge i_clk_sys);
  endtask

  // one write strobe; counts and words of the captured writes
  task automatic t_wr(input chf_pkg::chf_mode_t m, input logic rn, input logic [15:0] d,
    input logic [15:0] et, input logic [15:0] ec);
    int a, b;
    a = n_task;
    b = n_cfg;
    i_mode <= m;
    i_reg_n <= rn;
    i_host_data <= d;
    i_addr <= d[3:0];
    i_we_n <= 1'b0;
    repeat (4) @(posedge i_clk_sys);
    i_we_n <= 1'b1;
    repeat (10) @(posedge i_clk_sys);
    chk("task count", et, 16'(n_task - a));
    chk("cfg count", ec, 16'(n_cfg - b));
    if (et != 0) chk("task word", d, w_task);
    if (ec != 0) chk("cfg word", d, w_cfg);
  endtask

  // data-in ready follows the core, drops to pause, idles high
  task automatic t_rdy;
    i_mode <= DSK;
    i_udma_write <= 1'b1;
    i_core_can_take <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
    #1 chk("dmardy on", 16'h0, {15'h0, o_dmardy_n});
    @(posedge i_clk_sys);
    i_core_can_take <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    #1 chk("dmardy pause", 16'h1, {15'h0, o_dmardy_n});
    @(posedge i_clk_sys);
    i_udma_write <= 1'b0;
    i_core_can_take <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    #1 chk("dmardy idle", 16'h1, {15'h0, o_dmardy_n});
    @(posedge i_clk_sys);
  endtask

  // fill the buffer while stalled, strobe must hold, then drain to the host
  task automatic t_out;
    int n;
    logic r, s0;
    n = 0;
    i_mode <= DSK;
    i_out_valid <= 1'b1;
    i_out_data <= 16'ha000;
    repeat (6) begin
      @(negedge i_clk_sys) r = o_out_ready;
      @(posedge i_clk_sys);
      if (r) begin
        n++;
        i_out_data <= 16'ha000 + 16'(n);
      end
    end
    i_out_valid <= 1'b0;
    chk("held words", 16'h2, 16'(n));
    s0 = o_dstrobe;
    repeat (40) @(posedge i_clk_sys);
    chk("strobe still", {15'h0, s0}, {15'h0, o_dstrobe});
    i_udma_read <= 1'b1;
    repeat (200) @(posedge i_clk_sys);
    chk("words seen", 16'h2, {8'h0, host_cnt});
    chk("last word", 16'ha001, host_last);
    chk("drained", 16'h1, {15'h0, o_out_ready});
    s0 = o_dstrobe;
    repeat (40) @(posedge i_clk_sys);
    chk("strobe paused", {15'h0, s0}, {15'h0, o_dstrobe});
    i_out_valid <= 1'b1;
    i_out_data <= 16'h5aa5;
    @(posedge i_clk_sys);
    i_out_valid <= 1'b0;
    repeat (100) @(posedge i_clk_sys);
    chk("resumed words", 16'h3, {8'h0, host_cnt});
    chk("resumed word", 16'h5aa5, host_last);
    i_udma_read <= 1'b0;
  endtask

  initial begin
    repeat (12) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
    t_wait(MEM, 1'b0, 1'b0);
    t_wait(IOM, 1'b0, 1'b0);
    t_wait(DSK, 1'b0, 1'b0);
    t_wait(DSK, 1'b1, 1'b1);
    t_wr(MEM, 1'b1, 16'h5a3c, 16'h1, 16'h0);
    t_wr(MEM, 1'b0, 16'hc3a5, 16'h0, 16'h1);
    t_wr(IOM, 1'b0, 16'h1234, 16'h0, 16'h1);
    t_wr(IOM, 1'b1, 16'h2468, 16'h0, 16'h0);
    t_wr(DSK, 1'b0, 16'h4321, 16'h0, 16'h0);
    t_rdy;
    t_out;
    end_sim;
  end

  // the whole run needs well under 1500 system cycles
  initial begin
    #50000;
    num_errors++;
    end_sim;
  end
endmodule

bind chf_flow chf_flow_checker u_chk (.*);
